// *** include/lcj_pkg.sv ***
// Constants, encodings and state codes for the loop, call, jump and increment unit.
package lcj_pkg;
  localparam logic [7:0]  OP_PREFIX      = 8'hA5;
  localparam logic [7:0]  OP_INC_ACC     = 8'h04;
  localparam logic [7:0]  OP_INC_DIR     = 8'h05;
  localparam logic [6:0]  OP_INC_IND     = 7'h03;
  localparam logic [4:0]  OP_INC_REG     = 5'h01;
  localparam logic [7:0]  OP_INC_SHORT   = 8'h0B;
  localparam logic [7:0]  OP_DBNZ_DIR    = 8'hD5;
  localparam logic [4:0]  OP_DBNZ_REG    = 5'h1B;
  localparam logic [7:0]  OP_EXT_CALL    = 8'h9A;
  localparam logic [7:0]  OP_EXT_JUMP    = 8'h8A;
  localparam logic [7:0]  OP_EXT_RET     = 8'hAA;
  localparam logic [7:0]  OP_INC_DATA_POINTER_HW = 8'hA3;
  localparam logic [1:0]  SZ_BYTE        = 2'h0;
  localparam logic [1:0]  SZ_WORD        = 2'h1;
  localparam logic [1:0]  SZ_BAD         = 2'h2;
  localparam logic [1:0]  SZ_DWORD       = 2'h3;
  localparam logic [1:0]  ADD_SEL_ONE    = 2'h0;
  localparam logic [1:0]  ADD_SEL_TWO    = 2'h1;
  localparam logic [1:0]  ADD_SEL_FOUR   = 2'h2;
  localparam logic [1:0]  ADD_SEL_BAD    = 2'h3;
  localparam logic [31:0] ADDEND_ONE     = 32'h0000_0001;
  localparam logic [31:0] ADDEND_TWO     = 32'h0000_0002;
  localparam logic [31:0] ADDEND_FOUR    = 32'h0000_0004;
  localparam logic [7:0]  BYTE_ONE       = 8'h01;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [15:0] HWORD_ONE      = 16'h0001;
  localparam logic [23:0] LEN_DBNZ_DIR   = 24'h00_0003;
  localparam logic [23:0] LEN_DBNZ_REG   = 24'h00_0002;
  localparam logic [23:0] LEN_EXT_CALL   = 24'h00_0004;
  localparam logic [1:0]  PORT_EXTRA     = 2'h2;
  localparam logic [1:0]  STACK_BYTES    = 2'h3;
  localparam logic [1:0]  POP_LAST       = 2'h2;
  localparam logic [1:0]  CNT_ZERO       = 2'h0;
  localparam logic [1:0]  CNT_ONE        = 2'h1;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_EXEC = 5'h02,
    ST_WAIT = 5'h04,
    ST_PUSH = 5'h08,
    ST_POP  = 5'h10
  } lcj_state_t;
endpackage

// *** logic/lcj_exec.sv ***
// Execution unit for decrement-branch, extended call, jump, return and increments.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Decrement operand by one; branch only when the new value is nonzero.
// - Branch target is address of next instruction plus signed last byte.
// - Operand is register or direct byte; zero wraps to all ones.
// - Read-modify-write of an output port uses the output latch value.
// - Call adds four to PC, pushes 24-bit return high byte first, SP+3.
// - Call loads PC high byte from byte two, low word from bytes three, four.
// - Call and jump targets are full 24-bit addresses.
// - Extended jump is unconditional and loads PC from bytes two to four.
// - Return changes no condition flag.
// - Direct increment of a port takes two extra states.
// - Short increment adds 1, 2 or 4 to byte, word or double word, wrapping.
// - Data pointer increment is a 16-bit add of one with low-to-high carry.
// - Data pointer overflow never carries into the extended upper word.
// - Source mode needs the A5 prefix for register and indirect forms.
module lcj_exec (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // Instruction
  input  wire logic        i_start,
  input  wire logic        i_source_mode,
  input  wire logic [39:0] i_instr,
  input  wire logic [23:0] i_pc,
  // Operands
  input  wire logic [31:0] i_operand,
  input  wire logic        i_dir_is_port,
  input  wire logic [7:0]  i_port_latch,
  input  wire logic [15:0] i_data_pointer,
  input  wire logic [15:0] i_sp,
  input  wire logic [7:0]  i_stack_rdata,
  // Completion
  output logic             o_busy,
  output logic             o_done,
  output logic             o_illegal,
  output logic             o_branch_taken,
  // Results
  output logic [23:0]      o_pc,
  output logic             o_pc_we,
  output logic [31:0]      o_result,
  output logic [1:0]       o_result_size,
  output logic [3:0]       o_reg_index,
  output logic             o_result_we,
  output logic [15:0]      o_data_pointer,
  output logic             o_data_pointer_we,
  output logic             o_flag_n,
  output logic             o_flag_z,
  output logic             o_flag_we,
  // Stack
  output logic [15:0]      o_sp,
  output logic             o_sp_we,
  output logic [15:0]      o_stack_addr,
  output logic [7:0]       o_stack_wdata,
  output logic             o_stack_we,
  output logic             o_stack_re
);
  import lcj_pkg::*;

  function automatic logic [7:0] ibyte(input logic [39:0] w, input logic [2:0] k);
    logic [39:0] s;
    s = w << {k, 3'h0};
    return s[39:32];
  endfunction

  function automatic logic [31:0] fit(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      SZ_BYTE: return {24'h00_0000, v[7:0]};
      SZ_WORD: return {16'h0000, v[15:0]};
      default: return v;
    endcase
  endfunction

  // Returns the negative and zero flags of a value of the given size.
  function automatic logic [1:0] nz(input logic [31:0] v, input logic [1:0] sz);
    logic neg;
    neg = (sz == SZ_BYTE) ? v[7] : ((sz == SZ_WORD) ? v[15] : v[31]);
    return {neg, fit(v, sz) == 32'h0000_0000};
  endfunction

  function automatic logic [31:0] addend(input logic [1:0] sel);
    case (sel)
      ADD_SEL_ONE: return ADDEND_ONE;
      ADD_SEL_TWO: return ADDEND_TWO;
      default:     return ADDEND_FOUR;
    endcase
  endfunction

  lcj_state_t  state_q;
  lcj_state_t  state_d;
  logic [1:0]  cnt_q;
  logic        pre;
  logic        ext_ok;
  logic        leg_ok;
  logic [2:0]  opi;
  logic [7:0]  op;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic        is_inc_acc;
  logic        is_inc_dir;
  logic        is_inc_ind;
  logic        is_inc_reg;
  logic        is_inc_byte;
  logic        is_short;
  logic        is_dbnz_dir;
  logic        is_dbnz;
  logic        is_ext_call;
  logic        is_ext_jump;
  logic        is_ext_ret;
  logic        is_inc_dp;
  logic        is_known;
  logic        port_wait;
  logic [7:0]  src8;
  logic [7:0]  dec8;
  logic [7:0]  rel;
  logic [23:0] next_pc;
  logic [23:0] target;
  logic [23:0] ret_addr;
  logic [15:0] dp_sum;
  logic        fin;

  always_comb begin
    pre    = (ibyte(i_instr, 3'h0) == OP_PREFIX);
    ext_ok = i_source_mode ? !pre : pre;
    leg_ok = i_source_mode ? pre : !pre;
    opi    = {2'h0, pre};
    op     = ibyte(i_instr, opi);
    b1     = ibyte(i_instr, opi + 3'h1);
    b2     = ibyte(i_instr, opi + 3'h2);
    b3     = ibyte(i_instr, opi + 3'h3);
    // Accumulator, direct and data pointer forms exist only unprefixed in both modes.
    is_inc_acc  = !pre && (op == OP_INC_ACC);
    is_inc_dir  = !pre && (op == OP_INC_DIR);
    is_inc_ind  = leg_ok && (op[7:1] == OP_INC_IND);
    is_inc_reg  = leg_ok && (op[7:3] == OP_INC_REG);
    is_inc_byte = is_inc_acc || is_inc_dir || is_inc_ind || is_inc_reg;
    is_short    = ext_ok && (op == OP_INC_SHORT) && (b1[1:0] != ADD_SEL_BAD)
                  && (b1[3:2] != SZ_BAD);
    is_dbnz_dir = !pre && (op == OP_DBNZ_DIR);
    is_dbnz     = is_dbnz_dir || (leg_ok && (op[7:3] == OP_DBNZ_REG));
    is_ext_call = ext_ok && (op == OP_EXT_CALL);
    is_ext_jump = ext_ok && (op == OP_EXT_JUMP);
    is_ext_ret  = ext_ok && (op == OP_EXT_RET);
    is_inc_dp   = !pre && (op == OP_INC_DATA_POINTER_HW);
    is_known    = is_inc_byte || is_short || is_dbnz || is_inc_dp
                  || is_ext_call || is_ext_jump || is_ext_ret;
    port_wait   = is_inc_dir && i_dir_is_port;
    // Port operands come from the output latch, never from the pins.
    src8 = ((is_inc_dir || is_dbnz_dir) && i_dir_is_port) ? i_port_latch
                                                          : i_operand[7:0];
    dec8     = src8 - BYTE_ONE;
    rel      = is_dbnz_dir ? b2 : b1;
    next_pc  = i_pc + (is_dbnz_dir ? LEN_DBNZ_DIR
                                   : LEN_DBNZ_REG + {23'h00_0000, pre});
    target   = next_pc + {{16{rel[7]}}, rel};
    ret_addr = i_pc + LEN_EXT_CALL;
    dp_sum   = i_data_pointer + HWORD_ONE;
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (i_start) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (port_wait) begin
          state_d = ST_WAIT;
        end else if (is_ext_call) begin
          state_d = ST_PUSH;
        end else if (is_ext_ret) begin
          state_d = ST_POP;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (cnt_q == CNT_ONE) begin
          state_d = ST_IDLE;
        end
      end
      ST_PUSH: begin
        if (cnt_q == STACK_BYTES) begin
          state_d = ST_IDLE;
        end
      end
      ST_POP: begin
        if (cnt_q == POP_LAST) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    fin = (state_q != ST_IDLE) && (state_d == ST_IDLE);
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= CNT_ZERO;
    end else if (state_q == ST_EXEC) begin
      cnt_q <= port_wait ? PORT_EXTRA : (is_ext_call ? CNT_ONE : CNT_ZERO);
    end else if (state_q == ST_WAIT) begin
      cnt_q <= cnt_q - CNT_ONE;
    end else if ((state_q == ST_PUSH) || (state_q == ST_POP)) begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  // Result value and flags.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_result       <= 32'h0000_0000;
      o_result_size  <= SZ_BYTE;
      o_reg_index    <= 4'h0;
      o_data_pointer <= 16'h0000;
      o_flag_n       <= 1'b0;
      o_flag_z       <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      o_reg_index <= b1[7:4];
      if (is_inc_byte) begin
        o_result              <= {24'h00_0000, src8 + BYTE_ONE};
        o_result_size         <= SZ_BYTE;
        {o_flag_n, o_flag_z}  <= nz({24'h00_0000, src8 + BYTE_ONE}, SZ_BYTE);
      end else if (is_short) begin
        o_result              <= fit(i_operand + addend(b1[1:0]), b1[3:2]);
        o_result_size         <= b1[3:2];
        {o_flag_n, o_flag_z}  <= nz(i_operand + addend(b1[1:0]), b1[3:2]);
      end else if (is_dbnz) begin
        o_result              <= {24'h00_0000, dec8};
        o_result_size         <= SZ_BYTE;
        {o_flag_n, o_flag_z}  <= nz({24'h00_0000, dec8}, SZ_BYTE);
      end else if (is_inc_dp) begin
        o_data_pointer        <= dp_sum;
        {o_flag_n, o_flag_z}  <= nz({16'h0000, dp_sum}, SZ_WORD);
      end
    end
  end

  // Program counter and stack traffic.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_pc          <= 24'h00_0000;
      o_sp          <= 16'h0000;
      o_stack_addr  <= 16'h0000;
      o_stack_wdata <= BYTE_ZERO;
      o_stack_we    <= 1'b0;
      o_stack_re    <= 1'b0;
    end else begin
      unique case (state_q)
        ST_EXEC: begin
          o_stack_we <= is_ext_call;
          o_stack_re <= is_ext_ret;
          if (is_dbnz) begin
            o_pc <= (dec8 != BYTE_ZERO) ? target : next_pc;
          end else if (is_ext_call || is_ext_jump) begin
            o_pc <= {b1, b2, b3};
          end
          if (is_ext_call) begin
            o_stack_addr  <= i_sp + HWORD_ONE;
            o_sp          <= i_sp + HWORD_ONE;
            o_stack_wdata <= ret_addr[23:16];
          end else if (is_ext_ret) begin
            o_stack_addr <= i_sp;
            o_sp         <= i_sp;
          end
        end
        ST_PUSH: begin
          o_stack_we <= (cnt_q != STACK_BYTES);
          if (cnt_q != STACK_BYTES) begin
            o_stack_addr  <= o_stack_addr + HWORD_ONE;
            o_sp          <= o_sp + HWORD_ONE;
            o_stack_wdata <= (cnt_q == CNT_ONE) ? ret_addr[15:8] : ret_addr[7:0];
          end
        end
        ST_POP: begin
          o_stack_re   <= (cnt_q != POP_LAST);
          o_stack_addr <= o_stack_addr - HWORD_ONE;
          o_sp         <= o_sp - HWORD_ONE;
          case (cnt_q)
            CNT_ZERO: o_pc[23:16] <= i_stack_rdata;
            CNT_ONE:  o_pc[15:8]  <= i_stack_rdata;
            default:  o_pc[7:0]   <= i_stack_rdata;
          endcase
        end
        default: begin
          o_stack_we <= 1'b0;
          o_stack_re <= 1'b0;
        end
      endcase
    end
  end

  // Completion strobes decode the instruction, which is held stable until done.
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_busy            <= 1'b0;
      o_done            <= 1'b0;
      o_illegal         <= 1'b0;
      o_branch_taken    <= 1'b0;
      o_pc_we           <= 1'b0;
      o_result_we       <= 1'b0;
      o_data_pointer_we <= 1'b0;
      o_flag_we         <= 1'b0;
      o_sp_we           <= 1'b0;
    end else begin
      o_busy            <= (state_d != ST_IDLE);
      o_done            <= fin;
      o_illegal         <= fin && !is_known;
      o_branch_taken    <= fin && is_dbnz && (dec8 != BYTE_ZERO);
      o_pc_we           <= fin && (is_dbnz || is_ext_call || is_ext_jump || is_ext_ret);
      o_result_we       <= fin && (is_inc_byte || is_short || is_dbnz);
      o_data_pointer_we <= fin && is_inc_dp;
      // Calls, jumps and returns leave every flag alone.
      o_flag_we         <= fin && (is_inc_byte || is_short || is_dbnz || is_inc_dp);
      o_sp_we           <= fin && (is_ext_call || is_ext_ret);
    end
  end
endmodule
`default_nettype wire

// *** tb/lcj_exec_props.sv ***
// Concurrent checks on the ports of the loop, call, jump and increment unit.
`timescale 1ns/100ps
`default_nettype none
module lcj_exec_props (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  // Observed ports
  input wire logic        i_start,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_pc_we,
  input wire logic        o_result_we,
  input wire logic        o_flag_we,
  input wire logic [15:0] o_sp,
  input wire logic        o_sp_we,
  input wire logic [15:0] o_stack_addr,
  input wire logic        o_stack_we,
  input wire logic        o_stack_re
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  start_sets_busy_a: assert property (i_start && !o_busy |=> o_busy)
    else $error("start not followed by busy");
  done_bound_a: assert property ($rose(o_busy) |-> ##[1:4] o_done)
    else $error("instruction did not finish in time");
  strobe_done_a: assert property (o_pc_we || o_result_we || o_sp_we |-> o_done)
    else $error("write strobe outside completion");
  push_three_a: assert property ($rose(o_stack_we) |-> o_stack_we [*3] ##1 !o_stack_we)
    else $error("call did not push three bytes");
  push_step_a: assert property (o_stack_we && $past(o_stack_we) |->
    o_stack_addr == $past(o_stack_addr) + 16'h0001)
    else $error("push address did not step up");
  call_sp_a: assert property (o_sp_we && $past(o_stack_we) |->
    o_sp == $past(o_stack_addr))
    else $error("stack pointer after call wrong");
  pop_three_a: assert property ($rose(o_stack_re) |-> o_stack_re [*3] ##1 !o_stack_re)
    else $error("return did not pop three bytes");
  pop_step_a: assert property (o_stack_re && $past(o_stack_re) |->
    o_stack_addr == $past(o_stack_addr) - 16'h0001)
    else $error("pop address did not step down");
  ret_sp_a: assert property (o_sp_we && $past(o_stack_re) |->
    o_sp == $past(o_stack_addr) - 16'h0001)
    else $error("stack pointer after return wrong");
  ret_flags_a: assert property (o_sp_we |-> !o_flag_we)
    else $error("flags written by call or return");
endmodule

bind lcj_exec lcj_exec_props props_u (
  .i_clk_sys   (i_clk_sys),
  .i_reset     (i_reset),
  .i_start     (i_start),
  .o_busy      (o_busy),
  .o_done      (o_done),
  .o_pc_we     (o_pc_we),
  .o_result_we (o_result_we),
  .o_flag_we   (o_flag_we),
  .o_sp        (o_sp),
  .o_sp_we     (o_sp_we),
  .o_stack_addr(o_stack_addr),
  .o_stack_we  (o_stack_we),
  .o_stack_re  (o_stack_re)
);
`default_nettype wire

// *** tb/test_loop_call_jump_increment_exec.sv ***
// Self-checking testbench for the loop, call, jump and increment unit.
`timescale 1ns/100ps
`default_nettype none
module test_loop_call_jump_increment_exec;
  import lcj_pkg::*;
  logic        i_clk_sys = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_start = 1'b0;
  logic        i_source_mode = 1'b0;
  logic [39:0] i_instr = 40'h0;
  logic [23:0] i_pc = 24'h0;
  logic [31:0] i_operand = 32'h0;
  logic        i_dir_is_port = 1'b0;
  logic [7:0]  i_port_latch = 8'h0;
  logic [15:0] i_data_pointer = 16'h0;
  logic [15:0] i_sp = 16'h0;
  logic [7:0]  i_stack_rdata;
  logic        o_busy, o_done, o_illegal, o_branch_taken, o_pc_we, o_result_we;
  logic        o_data_pointer_we, o_flag_n, o_flag_z, o_flag_we, o_sp_we, o_stack_we, o_stack_re;
  logic [23:0] o_pc;
  logic [31:0] o_result;
  logic [1:0]  o_result_size;
  logic [3:0]  o_reg_index;
  logic [15:0] o_data_pointer, o_sp, o_stack_addr;
  logic [7:0]  o_stack_wdata;
  int          fails = 0;
  int          samples_checked = 0;
  int          seed = 36479;
  int          f;
  logic [31:0] r, v, e, m;
  logic [39:0] ins;
  logic [23:0] pc, len;
  logic [15:0] sp;
  logic [7:0]  op;
  logic [1:0]  sz, sel;
  logic        sm;
  logic [23:0] pushq[$];
  logic [7:0]  stk[0:255];

  lcj_exec dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_start(i_start),
    .i_source_mode(i_source_mode), .i_instr(i_instr), .i_pc(i_pc), .i_operand(i_operand),
    .i_dir_is_port(i_dir_is_port), .i_port_latch(i_port_latch),
    .i_data_pointer(i_data_pointer), .i_sp(i_sp), .i_stack_rdata(i_stack_rdata),
    .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_branch_taken(o_branch_taken),
    .o_pc(o_pc), .o_pc_we(o_pc_we), .o_result(o_result), .o_result_size(o_result_size),
    .o_reg_index(o_reg_index), .o_result_we(o_result_we), .o_data_pointer(o_data_pointer),
    .o_data_pointer_we(o_data_pointer_we), .o_flag_n(o_flag_n), .o_flag_z(o_flag_z),
    .o_flag_we(o_flag_we), .o_sp(o_sp), .o_sp_we(o_sp_we), .o_stack_addr(o_stack_addr),
    .o_stack_wdata(o_stack_wdata), .o_stack_we(o_stack_we), .o_stack_re(o_stack_re));

  always #4 i_clk_sys = ~i_clk_sys;
  assign i_stack_rdata = stk[o_stack_addr[7:0]];

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Starts one instruction and waits for completion, logging every stack write.
  task automatic exec(input logic [39:0] code, input logic mode, input int cyc);
    int n;
    n = 0;
    i_instr = code;
    i_source_mode = mode;
    i_start = 1'b1;
    pushq.delete();
    @(posedge i_clk_sys) #1;
    i_start = 1'b0;
    chk(o_busy, 1'b1);
    do begin
      @(posedge i_clk_sys) #1;
      n++;
      if (o_stack_we === 1'b1) begin
        pushq.push_back({o_stack_addr, o_stack_wdata});
      end
    end while (o_done !== 1'b1 && n < 10);
    chk(n, cyc);
    chk({o_busy, o_done}, 2'b01);
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fails++;
    finish_test();
  end

  initial begin
    for (int a = 0; a < 256; a++) begin
      stk[a] = 8'(a ^ 8'h5A);
    end
    repeat (2) @(posedge i_clk_sys);
    #1 i_reset = 1'b0;
    @(posedge i_clk_sys) #1;
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      v = k[0] ? 32'h0 : (k[1] ? 32'h1 : {24'h0, r[15:8]});
      sm = r[16];
      i_operand = v;
      i_pc = {r[7:0], r[31:16]};
      if (k[2]) begin
        ins = sm ? {OP_PREFIX, OP_DBNZ_REG, 3'h5, r[7:0], 16'h0}
                 : {OP_DBNZ_REG, 3'h5, r[7:0], 24'h0};
      end else begin
        ins = {OP_DBNZ_DIR, 8'h30, r[7:0], 16'h0};
      end
      len = k[2] ? 24'h00_0002 + {23'h0, sm} : 24'h00_0003;
      exec(ins, sm, 1);
      e = (v - 32'h1) & 32'hFF;
      pc = i_pc + len + ((e != 0) ? {{16{r[7]}}, r[7:0]} : 24'h0);
      chk(o_result, e);
      chk(o_pc, pc);
      chk({o_flag_n, o_flag_z}, {e[7], e == 0});
      chk({o_branch_taken, o_pc_we, o_result_we, o_flag_we, o_illegal}, {e != 0, 4'b1110});
    end
    for (int k = 0; k < 10; k++) begin
      r = $random(seed);
      f = k / 2;
      sm = k[0];
      v = (k % 3 == 0) ? 32'hFF : {24'h0, r[7:0]};
      i_dir_is_port = (f == 2);
      i_port_latch = v[7:0];
      i_operand = (f == 2) ? {24'h0, ~v[7:0]} : v;
      case (f)
        0: ins = {OP_INC_ACC, 32'h0};
        1, 2: ins = {OP_INC_DIR, 8'h40, 24'h0};
        3: ins = sm ? {OP_PREFIX, OP_INC_IND, 1'b1, 24'h0} : {OP_INC_IND, 1'b1, 32'h0};
        default: ins = sm ? {OP_PREFIX, OP_INC_REG, 3'h2, 24'h0} : {OP_INC_REG, 3'h2, 32'h0};
      endcase
      exec(ins, sm, (f == 2) ? 3 : 1);
      e = (v + 32'h1) & 32'hFF;
      chk(o_result, e);
      chk({o_flag_n, o_flag_z}, {e[7], e == 0});
      chk({o_result_we, o_flag_we, o_pc_we, o_illegal}, 4'b1100);
    end
    i_dir_is_port = 1'b0;
    for (int k = 0; k < 18; k++) begin
      r = $random(seed);
      sz = (k % 3 == 0) ? SZ_BYTE : ((k % 3 == 1) ? SZ_WORD : SZ_DWORD);
      sel = 2'((k / 3) % 3);
      sm = (k >= 9);
      m = (sz == SZ_BYTE) ? 32'hFF : ((sz == SZ_WORD) ? 32'hFFFF : 32'hFFFF_FFFF);
      v = m - {30'h0, r[1:0]};
      i_operand = v;
      ins = sm ? {OP_INC_SHORT, r[7:4], sz, sel, 24'h0}
               : {OP_PREFIX, OP_INC_SHORT, r[7:4], sz, sel, 16'h0};
      exec(ins, sm, 1);
      e = (v + (32'h1 << sel)) & m;
      chk(o_result, e);
      chk({o_result_size, o_reg_index}, {sz, r[7:4]});
      chk({o_result_we, o_flag_we, o_illegal}, 3'b110);
      chk(o_flag_z, e == 0);
    end
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      v = (k == 0) ? 32'hFFFF : ((k == 1) ? 32'h12FF : {16'h0, r[15:0]});
      i_data_pointer = v[15:0];
      exec({OP_INC_DATA_POINTER_HW, 32'h0}, k[0], 1);
      e = (v + 32'h1) & 32'hFFFF;
      chk(o_data_pointer, e);
      chk({o_data_pointer_we, o_flag_we, o_result_we, o_pc_we}, 4'b1100);
      chk(o_flag_z, e == 0);
    end
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      sm = (k >= 3);
      i_pc = {r[7:0], r[31:16]};
      sp = {8'h0, 2'b10, r[29:24]};
      i_sp = sp;
      op = (k % 3 == 0) ? OP_EXT_CALL : ((k % 3 == 1) ? OP_EXT_JUMP : OP_EXT_RET);
      ins = sm ? {op, r[23:0], 8'h0} : {OP_PREFIX, op, r[23:0]};
      stk[sp[7:0]] = r[23:16];
      stk[sp[7:0] - 8'h1] = r[15:8];
      stk[sp[7:0] - 8'h2] = r[7:0];
      exec(ins, sm, (k % 3 == 1) ? 1 : 4);
      chk(o_pc, r[23:0]);
      chk({o_pc_we, o_flag_we, o_result_we, o_illegal}, 4'b1000);
      if (k % 3 != 1) begin
        chk({o_sp_we, o_pc_we, o_flag_we}, 3'b110);
        chk(o_sp, (k % 3 == 0) ? sp + 16'h3 : sp - 16'h3);
      end
      if (k % 3 == 0) begin
        pc = i_pc + 24'h00_0004;
        chk(pushq.size(), 3);
        for (int j = 0; j < 3; j++) begin
          chk(pushq[j], {sp + 16'(j + 1), pc[23 - 8 * j -: 8]});
        end
      end
    end
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: ins = {OP_PREFIX, OP_INC_ACC, 24'h0};
        1: ins = {OP_EXT_CALL, 32'h0};
        2: ins = {OP_PREFIX, OP_INC_SHORT, 4'h0, SZ_BAD, ADD_SEL_ONE, 16'h0};
        default: ins = {OP_INC_SHORT, 4'h0, SZ_BYTE, ADD_SEL_BAD, 24'h0};
      endcase
      exec(ins, k[1] & k[0], 1);
      chk({o_illegal, o_pc_we, o_result_we, o_flag_we, o_sp_we}, 5'h10);
    end
    finish_test();
  end
endmodule
`default_nettype wire
